// ---- hdl/mqr_cfg_chain.v ----
`include "mqr_regs.vh"

// ------------------------------------------------------------------
// Serial configuration load and daisy chain
// ------------------------------------------------------------------
module mqr_cfg_chain #(
  parameter CFG_BITS = `MQR_CFG_BITS
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire serial_mode_in,
  input wire sclk_rise_in,
  input wire serial_data_in,
  input wire config_enable_in_n,
  output reg config_done_chain_out,
  output reg serial_data_out,
  output wire ready_out,
  output wire [CFG_BITS-1:0] cfg_word_out
);
  reg [CFG_BITS-1:0] shift_q;
  reg [`MQR_CFG_CNT_W-1:0] count_q;
  reg done_q;

  wire [`MQR_CFG_CNT_W-1:0] last_cnt;
  assign last_cnt = CFG_BITS[`MQR_CFG_CNT_W-1:0];

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      shift_q <= {CFG_BITS{1'b0}};
      count_q <= {`MQR_CFG_CNT_W{1'b0}};
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (!serial_mode_in) begin
        // Default programming needs no serial bits.
        done_q <= 1'b1;
      end else if (sclk_rise_in && !config_enable_in_n) begin
        shift_q <= {shift_q[CFG_BITS-2:0], serial_data_in};
        count_q <= count_q + `MQR_ONE_CNT;
        if (count_q == last_cnt - `MQR_ONE_CNT) begin
          done_q <= 1'b1;
        end
      end
    end
  end

  // Before loading completes the chain output stays high so that
  // downstream devices wait their turn.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      config_done_chain_out <= 1'b1;
      serial_data_out <= 1'b0;
    end else begin
      config_done_chain_out <= ~done_q | config_enable_in_n;
      serial_data_out <= done_q & ~config_done_chain_out
        ? serial_data_in : 1'b0;
    end
  end

  assign ready_out = ~config_done_chain_out;
  assign cfg_word_out = shift_q;
endmodule // mqr_cfg_chain

// ---- hdl/mqr_read_select.v ----
`include "mqr_regs.vh"

// Contract
// - First edge after queue change outputs a word from the old queue.
// - Second edge after queue change presents the new queue's data.
// - Quadrant select uses address bits 1:0.
// - Bits 7:5 pick device out of eight; bits 4:2 ignored.
// - Quadrant captured on edge with flag strobe high; old word may emit.
// - Read from selected queue only when read enable low, except the new queue's head word that falls through on the second edge.
// - Queue select taken regardless of read enable.
// - Flag polling and direct quadrant select need no read enable.
// - Serial mode shifts data bit on serial clock rise while enable low.
// - Chain-out goes low after programming if enable-in is low.
// - After programming chain-out follows enable-in.
// - Low chain-out means ready for normal operation.
// - Address latched as new queue on edge with address strobe high; code ignores a strobe arriving in ST_OLD.
// - Address bits 4:0 select one of 32 queues.
// - Loaded device passes serial data straight through to next.
module mqr_read_select #(
  parameter DEVICE_ID = 3'h0,
  parameter DATA_W = `MQR_DATA_W,
  parameter FLAG_W = `MQR_FLAG_W,
  parameter NUM_Q = `MQR_NUM_QUEUES
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [`MQR_ADDR_W-1:0] read_queue_addr_in,
  input wire read_addr_strobe_in,
  input wire empty_flag_strobe_in,
  input wire read_en_n_in,
  input wire polled_mode_in,
  input wire serial_mode_in,
  input wire [NUM_Q-1:0] almost_empty_in,
  input wire [NUM_Q*DATA_W-1:0] queue_head_in,
  input wire sclk_in,
  input wire serial_data_in,
  input wire config_enable_in_n,
  output reg [DATA_W-1:0] data_out,
  output reg data_valid_out,
  output wire [`MQR_QUEUE_W-1:0] read_queue_out,
  output wire queue_pop_out,
  output reg [FLAG_W-1:0] almost_empty_flag_bus_out,
  output reg almost_empty_flag_bus_oe_out,
  output wire config_done_chain_out,
  output wire serial_data_out,
  output wire ready_out
);
  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  wire [`MQR_ADDR_W-1:0] addr_s;
  wire strobe_s;
  wire empty_flag_strobe_s;
  wire ren_s;
  wire ren_n_s;
  wire sclk_s;
  wire sdi_s;
  wire cfg_en_s;
  wire config_enable_n_s;

  // Active-low pins are inverted ahead of the synchroniser so that its
  // cleared state after reset reads as idle rather than as a request.
  mqr_sync2 #(
    .WIDTH(`MQR_ADDR_W + 6)
  ) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({read_queue_addr_in, read_addr_strobe_in,
      empty_flag_strobe_in, ~read_en_n_in, sclk_in, serial_data_in,
      ~config_enable_in_n}),
    .sync_out({addr_s, strobe_s, empty_flag_strobe_s, ren_s, sclk_s, sdi_s,
      cfg_en_s})
  );
  assign ren_n_s = ~ren_s;
  assign config_enable_n_s = ~cfg_en_s;

  // Serial clock is sampled, so it must run well below 10 MHz.
  reg sclk_prev_q;
  wire sclk_rise;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_prev_q;

  // ------------------------------------------------------------------
  // Configuration chain
  // ------------------------------------------------------------------
  wire ready;
  mqr_cfg_chain #(
    .CFG_BITS(`MQR_CFG_BITS)
  ) u_cfg (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .serial_mode_in(serial_mode_in),
    .sclk_rise_in(sclk_rise),
    .serial_data_in(sdi_s),
    .config_enable_in_n(config_enable_n_s),
    .config_done_chain_out(config_done_chain_out),
    .serial_data_out(serial_data_out),
    .ready_out(ready),
    .cfg_word_out()
  );
  assign ready_out = ready;

  // ------------------------------------------------------------------
  // Queue select and first-word-through sequencing
  // ------------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_OLD = 3'b010;
  localparam ST_NEW = 3'b100;

  reg [2:0] state_q;
  reg [`MQR_QUEUE_W-1:0] cur_q;
  reg [`MQR_QUEUE_W-1:0] pend_q;
  reg selected_q;

  wire dev_hit;
  wire q_sel;
  wire quad_sel;
  assign dev_hit =
    addr_s[`MQR_DEV_MSB:`MQR_DEV_LSB] == DEVICE_ID;
  // Strobe is ignored until loading is done, in case the host errs.
  assign q_sel = strobe_s & ready;
  assign quad_sel = empty_flag_strobe_s & ~polled_mode_in;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      cur_q <= `MQR_QUEUE_RST;
      pend_q <= `MQR_QUEUE_RST;
      selected_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (q_sel) begin
            pend_q <= addr_s[`MQR_QUEUE_MSB:`MQR_QUEUE_LSB];
            selected_q <= dev_hit;
            state_q <= ST_OLD;
          end
        end
        ST_OLD: begin
          cur_q <= pend_q;
          state_q <= ST_NEW;
        end
        ST_NEW: begin
          if (q_sel) begin
            pend_q <= addr_s[`MQR_QUEUE_MSB:`MQR_QUEUE_LSB];
            selected_q <= dev_hit;
            state_q <= ST_OLD;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // The edge after the select still serves the old queue; the edge after
  // that falls through the new queue's head word without a read enable.
  wire old_word;
  wire first_word_through;
  wire do_read;
  assign old_word = (state_q == ST_OLD);
  assign first_word_through = (state_q == ST_NEW) & selected_q;
  assign do_read = ~ren_n_s & selected_q & ready & ~old_word;
  assign queue_pop_out = do_read | first_word_through;
  assign read_queue_out = cur_q;

  wire [DATA_W-1:0] head_word;
  assign head_word = queue_head_in[cur_q*DATA_W +: DATA_W];

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      data_out <= {DATA_W{1'b0}};
      data_valid_out <= 1'b0;
    end else begin
      data_valid_out <= do_read | first_word_through | (old_word & ~ren_n_s);
      if (do_read | first_word_through | old_word) begin
        data_out <= head_word;
      end
    end
  end

  // ------------------------------------------------------------------
  // Almost-empty flag quadrant, direct or polled
  // ------------------------------------------------------------------
  reg [`MQR_QUAD_W-1:0] quad_q;
  reg quad_hit_q;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      quad_q <= `MQR_QUAD_RST;
      quad_hit_q <= 1'b0;
    end else if (polled_mode_in) begin
      quad_q <= quad_q + 2'h1;
      quad_hit_q <= 1'b1;
    end else if (quad_sel) begin
      quad_q <= addr_s[`MQR_QUAD_MSB:`MQR_QUAD_LSB];
      quad_hit_q <= dev_hit;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      almost_empty_flag_bus_out <= {FLAG_W{1'b1}};
      almost_empty_flag_bus_oe_out <= 1'b0;
    end else begin
      almost_empty_flag_bus_out <= almost_empty_in[quad_q*FLAG_W +: FLAG_W];
      almost_empty_flag_bus_oe_out <= quad_hit_q & ready;
    end
  end
endmodule // mqr_read_select

// ---- hdl/mqr_regs.vh ----
`ifndef MQR_REGS_VH
`define MQR_REGS_VH

// ------------------------------------------------------------------
// Read address field layout
// ------------------------------------------------------------------
`define MQR_ADDR_W 8
`define MQR_QUEUE_LSB 0
`define MQR_QUEUE_MSB 4
`define MQR_QUAD_LSB 0
`define MQR_QUAD_MSB 1
`define MQR_DEV_LSB 5
`define MQR_DEV_MSB 7

// ------------------------------------------------------------------
// Sizes and reset values
// ------------------------------------------------------------------
`define MQR_NUM_QUEUES 32
`define MQR_QUEUE_W 5
`define MQR_DEV_W 3
`define MQR_QUAD_W 2
`define MQR_FLAG_W 8
`define MQR_DATA_W 18
`define MQR_CFG_BITS 16
`define MQR_CFG_CNT_W 5
`define MQR_QUEUE_RST 5'h0
`define MQR_QUAD_RST 2'h0
`define MQR_ONE_CNT 5'h01

`endif

// ---- hdl/mqr_sync2.v ----
// ------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ------------------------------------------------------------------
module mqr_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // mqr_sync2

// ---- tb/mqr_host_cfg.sv ----
module mqr_host_cfg (
  input wire logic clk_in,
  output logic sclk_out,
  output logic sdata_out,
  output logic en_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Serial loader
  // ----------------------------------------------------------------
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    en_n_out = 1'b1;
  end
  // The serial clock runs at clk/8 only inside a frame, since the
  // device samples it.
  task automatic load(input logic [15:0] w, input int n);
    en_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdata_out = w[15-i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    sdata_out = ~w[16-n];
  endtask
  task automatic set_sdi(input logic v);
    @(negedge clk_in);
    sdata_out = v;
  endtask
  task automatic set_en(input logic v);
    @(negedge clk_in);
    en_n_out = v;
  endtask
endmodule // mqr_host_cfg

// ---- tb/mqr_read_select_bench.sv ----
module mqr_read_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] read_queue_addr_in = 8'h00;
  logic read_addr_strobe_in = 1'b0;
  logic empty_flag_strobe_in = 1'b0;
  logic read_en_n_in = 1'b1;
  logic polled_mode_in = 1'b0;
  logic serial_mode_in = 1'b1;
  logic [31:0] almost_empty_in = 32'h8421_f00f;
  logic [575:0] queue_head_in;
  logic sclk_in, serial_data_in, config_enable_in_n;
  logic [17:0] data_out;
  logic [4:0] read_queue_out;
  logic [7:0] almost_empty_flag_bus_out;
  logic data_valid_out, queue_pop_out, almost_empty_flag_bus_oe_out;
  logic config_done_chain_out, serial_data_out, ready_out;
  int failures = 0;
  int tests_run = 0;
  always #25 clk_in = ~clk_in;
  mqr_read_select uut (.clk_in, .sys_rst_in, .read_queue_addr_in,
    .read_addr_strobe_in, .empty_flag_strobe_in, .read_en_n_in,
    .polled_mode_in, .serial_mode_in, .almost_empty_in,
    .queue_head_in, .sclk_in, .serial_data_in, .config_enable_in_n,
    .data_out, .data_valid_out, .read_queue_out, .queue_pop_out,
    .almost_empty_flag_bus_out, .almost_empty_flag_bus_oe_out,
    .config_done_chain_out, .serial_data_out, .ready_out);
  mqr_host_cfg host (.clk_in, .sclk_out(sclk_in), .sdata_out(serial_data_in),
    .en_n_out(config_enable_in_n));
  // ----------------------------------------------------------------
  // Helpers and scenarios
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic t_config;
    host.load(16'ha5c3, 15);
    cyc(20);
    chk("early_done", config_done_chain_out, 1'b1);
    host.load(16'h8000, 1);
    for (int i = 0; i < 20 && config_done_chain_out; i++) cyc(1);
    chk("ready", ready_out, 1'b1);
    host.set_en(1'b1);
    cyc(6);
    chk("follow_hi", config_done_chain_out, 1'b1);
    host.set_en(1'b0);
    cyc(6);
    chk("follow_lo", config_done_chain_out, 1'b0);
    host.set_sdi(1'b1);
    cyc(4);
    chk("pass_hi", serial_data_out, 1'b1);
    host.set_sdi(1'b0);
    cyc(4);
    chk("pass_lo", serial_data_out, 1'b0);
    $display("config test done");
  endtask
  // Read enable stays high here, so the new word must come anyway.
  task automatic t_sel(input logic [4:0] q, old);
    logic [17:0] prev;
    prev = data_out;
    read_queue_addr_in = {3'h0, q};
    read_addr_strobe_in = 1'b1;
    cyc(1);
    read_addr_strobe_in = 1'b0;
    for (int i = 0; i < 12 && data_valid_out !== 1'b1; i++) begin
      prev = data_out;
      cyc(1);
    end
    chk("old_word", prev, 18'h0_0100 + old);
    chk("new_word", data_out, 18'h0_0100 + q);
    chk("queue", read_queue_out, q);
    cyc(8);
    $display("select test done");
  endtask
  task automatic t_read;
    int pops;
    pops = 0;
    read_en_n_in = 1'b0;
    cyc(1);
    read_en_n_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      pops += queue_pop_out;
      cyc(1);
    end
    chk("pops", pops, 1);
    $display("read test done");
  endtask
  task automatic t_flag(input logic [7:0] a, exp, input logic oe);
    read_queue_addr_in = a;
    empty_flag_strobe_in = 1'b1;
    cyc(1);
    empty_flag_strobe_in = 1'b0;
    cyc(8);
    chk("flag_oe", almost_empty_flag_bus_oe_out, oe);
    if (oe) chk("flags", almost_empty_flag_bus_out, exp);
    $display("flag test done");
  endtask
  // Mid-run reset into default programming with polled flags.
  task automatic t_polled;
    int k;
    logic [7:0] exp8;
    k = 0;
    sys_rst_in = 1'b1;
    serial_mode_in = 1'b0;
    polled_mode_in = 1'b1;
    cyc(2);
    sys_rst_in = 1'b0;
    cyc(4);
    chk("dflt_done", config_done_chain_out, 1'b0);
    chk("dflt_ready", ready_out, 1'b1);
    chk("poll_oe", almost_empty_flag_bus_oe_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      if (almost_empty_flag_bus_out == almost_empty_in[i*8 +: 8]) k = i;
    end
    for (int i = 1; i < 4; i++) begin
      exp8 = almost_empty_in[((k + i) % 4) * 8 +: 8];
      cyc(1);
      chk("poll_flags", almost_empty_flag_bus_out, exp8);
    end
    $display("polled test done");
  endtask
  initial begin
    for (int q = 0; q < 32; q++) queue_head_in[q*18 +: 18] = 18'h0_0100 + q;
    cyc(6);
    sys_rst_in = 1'b0;
    t_config;
    t_sel(5'h05, 5'h00);
    t_sel(5'h1f, 5'h05);
    t_read;
    for (int q = 0; q < 4; q++) begin
      t_flag({6'h07, q[1:0]}, almost_empty_in[q*8 +: 8], 1'b1);
    end
    t_flag(8'h61, 8'h00, 1'b0);
    t_polled;
    tally_and_finish;
  end
  // The tests need a few hundred cycles; this limit is far beyond that.
  initial begin
    #1000000;
    failures++;
    tally_and_finish;
  end
endmodule // mqr_read_select_bench

// ---- tb/mqr_read_select_sva.sv ----
module mqr_read_select_sva #(
  parameter NUM_Q = 32,
  parameter DEV_ID = 3'h0
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] read_queue_addr_in,
  input wire logic read_addr_strobe_in,
  input wire logic empty_flag_strobe_in,
  input wire logic read_en_n_in,
  input wire logic [NUM_Q-1:0] almost_empty_in,
  input wire logic serial_data_in,
  input wire logic config_enable_in_n,
  input wire logic data_valid_out,
  input wire logic [4:0] read_queue_out,
  input wire logic queue_pop_out,
  input wire logic [7:0] almost_empty_flag_bus_out,
  input wire logic almost_empty_flag_bus_oe_out,
  input wire logic config_done_chain_out,
  input wire logic serial_data_out,
  input wire logic ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  // While the chain output is high the flag bus must stay released.
  ready_rel_a: assert property (
    config_done_chain_out |=> !almost_empty_flag_bus_oe_out)
    else $error("flag bus driven before ready");
  chain_follow_a: assert property (
    $rose(config_enable_in_n) && ready_out |-> ##[1:5] config_done_chain_out)
    else $error("chain out did not follow enable");
  queue_sel_a: assert property (
    read_addr_strobe_in && ready_out && read_queue_addr_in[7:5] == DEV_ID
    ##1 $stable(read_queue_addr_in)[*7]
    |-> read_queue_out == read_queue_addr_in[4:0]) else $error("queue sel");
  valid_sel_a: assert property (
    read_addr_strobe_in && ready_out && read_queue_addr_in[7:5] == DEV_ID
    |-> ##[2:10] data_valid_out) else $error("no new word");
  flag_oe_a: assert property (
    empty_flag_strobe_in && ready_out ##1 $stable(read_queue_addr_in)[*7]
    |-> almost_empty_flag_bus_oe_out == (read_queue_addr_in[7:5] == DEV_ID))
    else $error("flag oe");
  flag_val_a: assert property (
    empty_flag_strobe_in && ready_out && read_queue_addr_in[7:5] == DEV_ID
    ##1 ($stable(read_queue_addr_in) && $stable(almost_empty_in))[*7]
    |-> almost_empty_flag_bus_out ==
    almost_empty_in[{read_queue_addr_in[1:0], 3'h0} +: 8]) else $error("flags");
  no_pop_a: assert property (
    (read_en_n_in && !read_addr_strobe_in)[*8] |-> !queue_pop_out)
    else $error("stray pop");
  data_pass_a: assert property (
    (ready_out && $stable(serial_data_in))[*5]
    |-> serial_data_out == serial_data_in) else $error("no pass");
  cover property (queue_pop_out);
  cover property (data_valid_out);
  cover property (almost_empty_flag_bus_oe_out);
endmodule // mqr_read_select_sva

bind mqr_read_select mqr_read_select_sva #(
  .NUM_Q(NUM_Q),
  .DEV_ID(DEVICE_ID)
) chk_i (.clk_in,
  .sys_rst_in, .read_queue_addr_in, .read_addr_strobe_in,
  .empty_flag_strobe_in, .read_en_n_in, .almost_empty_in, .serial_data_in,
  .config_enable_in_n, .data_valid_out, .read_queue_out, .queue_pop_out,
  .almost_empty_flag_bus_out, .almost_empty_flag_bus_oe_out,
  .config_done_chain_out, .serial_data_out, .ready_out);
